// ### aippc_pkg.sv
// package: register map, field layout, reset values and timing of the accel control bank
package aippc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam int unsigned AW = 12;
  localparam logic [9:0] IDX_PIN_B_CFG  = 10'h054;
  localparam logic [9:0] IDX_ROUTE      = 10'h058;
  localparam logic [9:0] IDX_SELF_TEST  = 10'h06d;
  localparam logic [9:0] IDX_PWR_CFG    = 10'h07c;
  localparam logic [9:0] IDX_PWR_SW     = 10'h07d;
  localparam logic [9:0] IDX_SRST       = 10'h07e;
  localparam logic [9:0] IDX_IRQ_STAT   = 10'h080;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h081;
  localparam logic [9:0] IDX_STATE      = 10'h082;

  // ---------------------------------------------------------------
  // field positions and writable masks
  // ---------------------------------------------------------------
  localparam int unsigned PB_IN_EN   = 4;
  localparam int unsigned PB_OUT_EN  = 3;
  localparam int unsigned PB_DRV     = 2;
  localparam int unsigned PB_POL     = 1;
  localparam logic [7:0]  PB_WMASK   = 8'h1e;
  localparam int unsigned RT_RDY_B   = 6;
  localparam int unsigned RT_WM_B    = 5;
  localparam int unsigned RT_FULL_B  = 4;
  localparam int unsigned RT_RDY_A   = 2;
  localparam int unsigned RT_WM_A    = 1;
  localparam int unsigned RT_FULL_A  = 0;
  localparam logic [7:0]  RT_WMASK   = 8'h77;
  // event / status bit order: {ready, watermark, full}
  localparam int unsigned EV_FULL    = 0;
  localparam int unsigned EV_WM      = 1;
  localparam int unsigned EV_RDY     = 2;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] PIN_B_CFG_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST     = 8'h00;
  localparam logic [7:0] SELF_TEST_RST = 8'h00;
  localparam logic [7:0] PWR_CFG_RST   = 8'h03;
  localparam logic [7:0] PWR_SW_RST    = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST  = 3'h0;
  localparam logic [7:0] ST_OFF        = 8'h00;
  localparam logic [7:0] ST_POS        = 8'h0d;
  localparam logic [7:0] ST_NEG        = 8'h09;
  localparam logic [7:0] PWR_SUSPEND   = 8'h03;
  localparam logic [7:0] PWR_ACTIVE    = 8'h00;
  localparam logic [7:0] ACC_ON        = 8'h04;
  localparam logic [7:0] SRST_KEY      = 8'hb6;
  localparam logic [15:0] ST_OFFSET    = 16'h0400;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SRST_DELAY_MS = 1;
  localparam int unsigned SRST_CYC =
    (SRST_DELAY_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } aippc_sample_s;

  typedef struct packed {
    logic out;
    logic oe;
  } aippc_pad_s;

endpackage

// ### aippc_top.sv
// module: accel interrupt pin, routing, self-test and power control register bank
//
// How it works
// - pin b config: bit4 input, bit3 output
// - route bit6 sends data-ready to pin b
// - route bit5 sends watermark to pin b
// - route bit4 sends full to pin b
// - route bit2 sends data-ready to pin a
// - route bit1 sends watermark to pin a
// - route bit0 sends full to pin a
// - active self-test adds or subtracts constant offset to samples
// - self-test codes: 0x0d plus, 0x09 minus
// - power config 0x03 suspend, 0x00 active
// - suspend stops acquiring samples
// - power switch 0x04 on, 0x00 off
// - writing 0xb6 to soft reset resets device
// - one millisecond later config returns to reset
// - soft reset accepted in every mode
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module aippc_top #(
  parameter int unsigned SRST_DELAY_CYC = aippc_pkg::SRST_CYC
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [aippc_pkg::AW-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire aippc_pkg::aippc_sample_s sample_in,
  input  wire logic                     fifo_wm_lvl,
  input  wire logic                     fifo_full_lvl,
  output aippc_pkg::aippc_sample_s      sample_out,
  output logic                          acq_on,
  output logic                          st_positive,
  output logic                          st_negative,
  output logic                          irq_pin_a,
  output aippc_pkg::aippc_pad_s         irq_pin_b_pad,
  input  wire logic                     irq_pin_b_in,
  output logic                          irq
);
  import aippc_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  pin_b_cfg_r;
  logic [7:0]  route_r;
  logic [7:0]  self_test_r;
  logic [7:0]  pwr_cfg_r;
  logic [7:0]  pwr_sw_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic        srst_busy_r;
  logic [31:0] srst_cnt_r;
  logic        srst_done;
  logic [2:0]  pin_b_sync_r;
  logic        pin_b_level_r;
  logic        drdy_r;
  logic        wm_prev_r;
  logic        full_prev_r;
  logic [2:0]  src_lvl;
  logic [2:0]  ev_set;
  logic [2:0]  stat_clr;

  // ---------------------------------------------------------------
  // apb slave, one wait state so every answer comes from a flop
  // ---------------------------------------------------------------
  logic [9:0] idx;
  logic       addr_ok;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] wbyte;
  logic [7:0] rd_val;
  logic       rd_hit;

  assign idx     = paddr[AW-1:2];
  assign wbyte   = pwdata[7:0];
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    unique case (idx)
      IDX_PIN_B_CFG: rd_val = pin_b_cfg_r;
      IDX_ROUTE:     rd_val = route_r;
      IDX_SELF_TEST: rd_val = self_test_r;
      IDX_PWR_CFG:   rd_val = pwr_cfg_r;
      IDX_PWR_SW:    rd_val = pwr_sw_r;
      IDX_SRST:      rd_val = 8'h00;
      IDX_IRQ_STAT:  rd_val = {5'h00, irq_stat_r};
      IDX_IRQ_MASK:  rd_val = {5'h00, irq_mask_r};
      IDX_STATE:     rd_val = {5'h00, srst_busy_r, pin_b_level_r, acq_on};
      default:       rd_hit = 1'b0;
    endcase
  end
  assign addr_ok = rd_hit && (paddr[1:0] == 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !addr_ok;
      prdata  <= (addr_ok && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers; soft reset restores them after delay
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_b_cfg_r <= PIN_B_CFG_RST;
      route_r     <= ROUTE_RST;
      self_test_r <= SELF_TEST_RST;
      pwr_cfg_r   <= PWR_CFG_RST;
      pwr_sw_r    <= PWR_SW_RST;
      irq_mask_r  <= IRQ_MASK_RST;
    end else if (srst_done) begin
      pin_b_cfg_r <= PIN_B_CFG_RST;
      route_r     <= ROUTE_RST;
      self_test_r <= SELF_TEST_RST;
      pwr_cfg_r   <= PWR_CFG_RST;
      pwr_sw_r    <= PWR_SW_RST;
      irq_mask_r  <= IRQ_MASK_RST;
    end else if (wr_done && addr_ok) begin
      unique case (idx)
        IDX_PIN_B_CFG: pin_b_cfg_r <= wbyte & PB_WMASK;
        IDX_ROUTE:     route_r     <= wbyte & RT_WMASK;
        // self-test stays until software rewrites it or a soft reset completes
        IDX_SELF_TEST: self_test_r <= wbyte;
        IDX_PWR_CFG:   pwr_cfg_r   <= wbyte;
        IDX_PWR_SW:    pwr_sw_r    <= wbyte;
        IDX_IRQ_MASK:  irq_mask_r  <= wbyte[2:0];
        default:       ;
      endcase
    end
  end

  // key write arms the timer in any power state; other values are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_busy_r <= 1'b0;
      srst_cnt_r  <= 32'h0000_0000;
    end else if (wr_done && idx == IDX_SRST && wbyte == SRST_KEY
                 && addr_ok) begin
      srst_busy_r <= 1'b1;
      srst_cnt_r  <= 32'h0000_0000;
    end else if (srst_busy_r) begin
      srst_cnt_r  <= srst_cnt_r + 32'h0000_0001;
      if (srst_done) begin
        srst_busy_r <= 1'b0;
      end
    end
  end
  assign srst_done = srst_busy_r && (srst_cnt_r == SRST_DELAY_CYC - 1);

  // ---------------------------------------------------------------
  // acquisition and self-test
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_on      <= 1'b0;
      st_positive <= 1'b0;
      st_negative <= 1'b0;
    end else begin
      acq_on      <= (pwr_cfg_r == PWR_ACTIVE) && (pwr_sw_r == ACC_ON);
      st_positive <= (self_test_r == ST_POS);
      st_negative <= (self_test_r == ST_NEG);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out <= '0;
      drdy_r     <= 1'b0;
    end else begin
      // samples are dropped, not held, while suspended or off
      sample_out.valid <= sample_in.valid && acq_on;
      drdy_r           <= sample_in.valid && acq_on;
      if (sample_in.valid && acq_on) begin
        if (st_positive) begin
          sample_out.data <= sample_in.data + ST_OFFSET;
        end else if (st_negative) begin
          sample_out.data <= sample_in.data - ST_OFFSET;
        end else begin
          sample_out.data <= sample_in.data;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt sources, sticky status, mask
  // ---------------------------------------------------------------
  assign src_lvl = {drdy_r, fifo_wm_lvl, fifo_full_lvl};
  assign ev_set  = {drdy_r, fifo_wm_lvl && !wm_prev_r, fifo_full_lvl && !full_prev_r};
  assign stat_clr = (rd_done && idx == IDX_IRQ_STAT) ? prdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wm_prev_r   <= 1'b0;
      full_prev_r <= 1'b0;
      irq_stat_r  <= 3'h0;
      irq         <= 1'b0;
    end else begin
      wm_prev_r   <= fifo_wm_lvl;
      full_prev_r <= fifo_full_lvl;
      // only bits the read returned are cleared; a new event wins
      irq_stat_r  <= (irq_stat_r & ~stat_clr) | ev_set;
      irq         <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // pin routing and pin b pad
  // ---------------------------------------------------------------
  logic act_a;
  logic act_b;
  logic lvl_b;

  assign act_a = (route_r[RT_RDY_A]  && src_lvl[EV_RDY])
              || (route_r[RT_WM_A]   && src_lvl[EV_WM])
              || (route_r[RT_FULL_A] && src_lvl[EV_FULL]);
  assign act_b = (route_r[RT_RDY_B]  && src_lvl[EV_RDY])
              || (route_r[RT_WM_B]   && src_lvl[EV_WM])
              || (route_r[RT_FULL_B] && src_lvl[EV_FULL]);
  assign lvl_b = pin_b_cfg_r[PB_POL] ? act_b : !act_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin_a     <= 1'b0;
      irq_pin_b_pad <= '0;
    end else begin
      irq_pin_a <= act_a;
      if (!pin_b_cfg_r[PB_OUT_EN]) begin
        irq_pin_b_pad <= '0;
      end else if (pin_b_cfg_r[PB_DRV]) begin
        irq_pin_b_pad.out <= 1'b0;
        irq_pin_b_pad.oe  <= !lvl_b;
      end else begin
        irq_pin_b_pad.out <= lvl_b;
        irq_pin_b_pad.oe  <= 1'b1;
      end
    end
  end

  // pin b as input: 3-flop sampler, a change counts once stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_b_sync_r  <= 3'h0;
      pin_b_level_r <= 1'b0;
    end else begin
      pin_b_sync_r <= {pin_b_sync_r[1:0], irq_pin_b_in};
      if (pin_b_cfg_r[PB_IN_EN] && pin_b_sync_r[1] == pin_b_sync_r[2]) begin
        pin_b_level_r <= pin_b_sync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_b_dir: assert property (irq_pin_b_pad.oe |-> $past(pin_b_cfg_r[PB_OUT_EN]))
    else $error("pin b driven while output disabled");
  a_pin_b_drain: assert property (
    (irq_pin_b_pad.oe && $past(pin_b_cfg_r[PB_DRV])) |-> !irq_pin_b_pad.out)
    else $error("open-drain pin b drove high");
  a_route_rdy_b: assert property (
    ($past(route_r[RT_RDY_B] && drdy_r && pin_b_cfg_r[PB_OUT_EN] && !pin_b_cfg_r[PB_DRV]))
    |-> irq_pin_b_pad.out == $past(pin_b_cfg_r[PB_POL]))
    else $error("ready not shown on pin b");
  a_route_wm_b: assert property (
    ($past(route_r[RT_WM_B] && fifo_wm_lvl && pin_b_cfg_r[PB_OUT_EN] && !pin_b_cfg_r[PB_DRV]))
    |-> irq_pin_b_pad.out == $past(pin_b_cfg_r[PB_POL]))
    else $error("watermark not shown on pin b");
  a_route_full_b: assert property (
    ($past(route_r[RT_FULL_B] && fifo_full_lvl && pin_b_cfg_r[PB_OUT_EN]
      && !pin_b_cfg_r[PB_DRV])) |-> irq_pin_b_pad.out == $past(pin_b_cfg_r[PB_POL]))
    else $error("full not shown on pin b");
  a_route_rdy_a: assert property ((route_r[RT_RDY_A] && drdy_r) |=> irq_pin_a)
    else $error("ready not shown on pin a");
  a_route_wm_a: assert property ((route_r[RT_WM_A] && fifo_wm_lvl) |=> irq_pin_a)
    else $error("watermark not shown on pin a");
  a_route_full_a: assert property ((route_r[RT_FULL_A] && fifo_full_lvl) |=> irq_pin_a)
    else $error("full not shown on pin a");
  a_pin_a_quiet: assert property ((route_r[2:0] == 3'h0) |=> !irq_pin_a)
    else $error("pin a active with no route");
  a_st_offset: assert property ((sample_in.valid && acq_on && st_positive)
    |=> sample_out.data == $past(sample_in.data) + ST_OFFSET)
    else $error("positive self-test offset missing");
  a_st_decode: assert property ((self_test_r == ST_NEG) [*2] |-> st_negative && !st_positive)
    else $error("negative self-test code not decoded");
  a_suspend_off: assert property ((pwr_cfg_r == PWR_SUSPEND) |=> !acq_on)
    else $error("acquiring in suspend");
  a_no_sample: assert property (!acq_on |=> !sample_out.valid)
    else $error("sample passed while not acquiring");
  a_switch_on: assert property (acq_on |-> $past(pwr_sw_r) == ACC_ON)
    else $error("acquiring while switched off");
  a_srst_arm: assert property (
    (wr_done && idx == IDX_SRST && wbyte == SRST_KEY && paddr[1:0] == 2'b00)
    |=> srst_busy_r && srst_cnt_r == 32'h0000_0000)
    else $error("soft reset key not taken");
  a_srst_restore: assert property (srst_done |=> pwr_cfg_r == PWR_CFG_RST
    && route_r == ROUTE_RST && pwr_sw_r == PWR_SW_RST && !srst_busy_r
    && pin_b_cfg_r == PIN_B_CFG_RST && self_test_r == SELF_TEST_RST)
    else $error("soft reset did not restore config");
  a_srst_hold: assert property ((srst_busy_r && !srst_done) |=> srst_busy_r)
    else $error("soft reset ended early");

  // ---------------------------------------------------------------
  // assertions: self-test, power, pin b input and output, interrupt status
  // ---------------------------------------------------------------
  a_st_negative: assert property ((sample_in.valid && acq_on && st_negative)
    |=> sample_out.data == $past(sample_in.data) - ST_OFFSET)
    else $error("negative self-test offset missing");
  a_st_plain: assert property (
    (sample_in.valid && acq_on && !st_positive && !st_negative)
    |=> sample_out.data == $past(sample_in.data))
    else $error("sample altered without self-test");
  a_st_pos_code: assert property (
    (self_test_r == ST_POS) [*2] |-> st_positive && !st_negative)
    else $error("positive self-test code not decoded");
  a_st_off: assert property (
    (self_test_r == ST_OFF) [*2] |-> !st_positive && !st_negative)
    else $error("self-test active while off code held");
  // only software or a finished soft reset may move the self-test code
  a_st_kept: assert property (
    (!(wr_done && idx == IDX_SELF_TEST) && !srst_done) |=> $stable(self_test_r))
    else $error("self-test setting changed by itself");
  a_active_on: assert property (
    (pwr_cfg_r == PWR_ACTIVE && pwr_sw_r == ACC_ON) |=> acq_on)
    else $error("not acquiring while active and on");
  a_off_idle: assert property (
    (pwr_sw_r != ACC_ON) |=> !acq_on)
    else $error("acquiring while switch holds off");
  a_pin_b_follow: assert property (
    (pin_b_cfg_r[PB_IN_EN] && pin_b_sync_r[1] == pin_b_sync_r[2])
    |=> pin_b_level_r == $past(pin_b_sync_r[2]))
    else $error("pin b input level not taken");
  a_pin_b_ignore: assert property (!pin_b_cfg_r[PB_IN_EN] |=> $stable(pin_b_level_r))
    else $error("pin b input level moved while disabled");
  a_push_pull: assert property (
    $past(pin_b_cfg_r[PB_OUT_EN] && !pin_b_cfg_r[PB_DRV]) |-> irq_pin_b_pad.oe)
    else $error("push-pull pin b not driven");
  a_pin_b_quiet: assert property (
    $past(route_r[RT_RDY_B:RT_FULL_B] == 3'h0 && pin_b_cfg_r[PB_OUT_EN] && !pin_b_cfg_r[PB_DRV])
    |-> irq_pin_b_pad.out == !$past(pin_b_cfg_r[PB_POL]))
    else $error("pin b active with no route");
  a_stat_set: assert property (ev_set[EV_WM] |=> irq_stat_r[EV_WM])
    else $error("watermark event not recorded");
  a_irq_level: assert property (|(irq_stat_r & irq_mask_r) |=> irq)
    else $error("irq low with unmasked status");

  c_srst_suspend: cover property (srst_done && pwr_cfg_r == PWR_SUSPEND);
  c_st_negative: cover property (sample_out.valid && st_negative);
  c_pin_b_drain: cover property (irq_pin_b_pad.oe && pin_b_cfg_r[PB_DRV]);
  c_st_sample: cover property (sample_out.valid && st_positive);
  c_irq_clear: cover property (irq ##[1:20] !irq);

endmodule // aippc_top

// ### aippc_host.sv
// host controller model: apb master for the accel control bank
`timescale 1ns/100ps
module aippc_host (
  input  wire logic                     pclk,
  output logic                          psel,
  output logic                          penable,
  output logic                          pwrite,
  output logic      [aippc_pkg::AW-1:0] paddr,
  output logic      [31:0]              pwdata,
  input  wire logic                     pready
);
  import aippc_pkg::*;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // ---------------------------------------------------------------
  // one transfer, request held until pready is seen at an edge
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines show a changed pattern, never the last value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // only the key value is ever sent to the soft reset word
  task automatic soft_reset();
    xfer(1'b1, {IDX_SRST, 2'b00}, {24'h0, SRST_KEY});
  endtask
endmodule // aippc_host

// ### tb.sv
// testbench: registers, routing, self-test, power and soft reset of the accel bank
`timescale 1ns/100ps
module tb;
  import aippc_pkg::*;
  localparam int unsigned DLY = 20;
  localparam logic [11:0] A_PB = {IDX_PIN_B_CFG, 2'b00};
  localparam logic [11:0] A_RT = {IDX_ROUTE, 2'b00};
  localparam logic [11:0] A_ST = {IDX_SELF_TEST, 2'b00};
  localparam logic [11:0] A_PC = {IDX_PWR_CFG, 2'b00};
  localparam logic [11:0] A_PS = {IDX_PWR_SW, 2'b00};
  localparam logic [11:0] A_SR = {IDX_SRST, 2'b00};
  localparam logic [11:0] A_IS = {IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_SS = {IDX_STATE, 2'b00};
  localparam logic [11:0] ADR [7] = '{A_PB, A_RT, A_ST, A_PC, A_PS, A_SR, A_MK};
  localparam logic [7:0]  RST [7] = '{PIN_B_CFG_RST, ROUTE_RST, SELF_TEST_RST, PWR_CFG_RST,
                                      PWR_SW_RST, 8'h00, 8'h00};
  localparam logic [7:0]  CFGS [5] = '{8'h0a, 8'h08, 8'h0c, 8'h0e, 8'h12};
  localparam logic [7:0]  RTS [2]  = '{8'h07, 8'h70};
  localparam logic [7:0]  STC [3]  = '{ST_POS, ST_NEG, ST_OFF};

  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          fifo_wm_lvl, fifo_full_lvl, acq_on, st_positive, st_negative;
  logic          irq_pin_a, irq_pin_b_in, irq;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, r, lfsr;
  aippc_sample_s sample_in, sample_out;
  aippc_pad_s    irq_pin_b_pad;
  logic [33:0]   apb_q [$];
  logic [15:0]   smp_q [$];
  logic [33:0]   e;
  int            failures, n_compared;

  always #2.5 pclk = ~pclk;
  // pin b has a pull-up on the board
  assign irq_pin_b_in = irq_pin_b_pad.oe ? irq_pin_b_pad.out : 1'b1;

  aippc_top #(.SRST_DELAY_CYC(DLY)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_in(sample_in), .fifo_wm_lvl(fifo_wm_lvl),
    .fifo_full_lvl(fifo_full_lvl), .sample_out(sample_out), .acq_on(acq_on),
    .st_positive(st_positive), .st_negative(st_negative), .irq_pin_a(irq_pin_a),
    .irq_pin_b_pad(irq_pin_b_pad), .irq_pin_b_in(irq_pin_b_in), .irq(irq));
  aippc_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic err = 1'b0);
    apb_q.push_back({1'b0, err, 32'h0});
    host.xfer(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic err = 1'b0);
    apb_q.push_back({1'b1, err, 24'h0, d});
    host.xfer(1'b0, a, 32'h0);
  endtask

  task automatic send(input logic [15:0] d, input logic [15:0] x, input logic keep);
    @(posedge pclk);
    sample_in <= {1'b1, d};
    if (keep) smp_q.push_back(x);
    @(posedge pclk);
    sample_in <= {1'b0, ~d};
  endtask

  // raise one event source and look at both pins while it is active
  task automatic ev(input int i, input logic [7:0] cfg, input logic [7:0] rt);
    logic lvl;
    lvl = cfg[PB_POL] ? rt[i+4] : ~rt[i+4];
    r = rnd();
    if (i == EV_RDY) send(r[15:0], r[15:0], 1'b1);
    else begin
      @(posedge pclk);
      if (i == EV_WM) fifo_wm_lvl <= 1'b1;
      else fifo_full_lvl <= 1'b1;
      @(posedge pclk);
    end
    @(posedge pclk);
    #1;
    chk({31'h0, irq_pin_a}, {31'h0, rt[i]}, "pin a");
    chk({30'h0, irq_pin_b_pad}, {30'h0, !cfg[PB_OUT_EN] ? 2'b00 :
        cfg[PB_DRV] ? {1'b0, ~lvl} : {lvl, 1'b1}}, "pin b");
    @(posedge pclk);
    fifo_wm_lvl   <= 1'b0;
    fifo_full_lvl <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // monitor: every answer takes the oldest note
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (apb_q.size() == 0) chk(32'h0, 32'h1, "unexpected bus answer");
      else begin
        e = apb_q.pop_front();
        chk({31'h0, pslverr}, {31'h0, e[32]}, "bus error flag");
        if (e[33]) chk(prdata, e[31:0], "read data");
      end
    end
    if (sample_out.valid === 1'b1) begin
      if (smp_q.size() == 0) chk(32'h0, 32'h1, "unexpected sample");
      else chk({16'h0, sample_out.data}, {16'h0, smp_q.pop_front()}, "sample");
    end
  end

  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0; presetn = 1'b0; sample_in = '0; fifo_wm_lvl = 1'b0; fifo_full_lvl = 1'b0;
    failures = 0; n_compared = 0; lfsr = 32'he177;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ADR[k]) rd(ADR[k], RST[k]);
    rd(12'h100, 8'h00, 1'b1);
    wr(12'h151, 8'h5a, 1'b1);
    r = rnd();
    wr(A_PB, r[7:0]);
    rd(A_PB, r[7:0] & PB_WMASK);
    wr(A_RT, r[15:8]);
    rd(A_RT, r[15:8] & RT_WMASK);
    wr(A_PC, PWR_ACTIVE);
    wr(A_PS, ACC_ON);
    repeat (2) @(posedge pclk);
    chk({31'h0, acq_on}, 32'h1, "acq on");
    foreach (CFGS[c]) foreach (RTS[m]) begin
      wr(A_PB, CFGS[c]);
      wr(A_RT, RTS[m]);
      for (int i = 0; i < 3; i++) ev(i, CFGS[c], RTS[m]);
    end
    // the last code written is the off code, ending self-test
    foreach (STC[s]) begin
      wr(A_ST, STC[s]);
      r = rnd();
      send(r[15:0], STC[s] == ST_POS ? r[15:0] + ST_OFFSET :
           STC[s] == ST_NEG ? r[15:0] - ST_OFFSET : r[15:0], 1'b1);
      repeat (2) @(posedge pclk);
      chk({30'h0, st_positive, st_negative}, {30'h0, STC[s] == ST_POS, STC[s] == ST_NEG},
          "self-test");
      rd(A_ST, STC[s]);
    end
    wr(A_PC, PWR_SUSPEND);
    repeat (2) @(posedge pclk);
    chk({31'h0, acq_on}, 32'h0, "acq off");
    send(r[31:16], 16'h0, 1'b0);
    // interrupt status: clear leftovers, masked event, unmasked event
    apb_q.push_back(34'h0);
    host.xfer(1'b0, A_IS, 32'h0);
    @(posedge pclk);
    fifo_full_lvl <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(A_IS, 8'h01);
    fifo_full_lvl <= 1'b0;
    wr(A_MK, 8'h07);
    fifo_wm_lvl <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(A_IS, 8'h02);
    fifo_wm_lvl <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // pin b as input only: released pad reads the pull-up level
    wr(A_PB, 8'h10);
    rd(A_SS, 8'h02);
    // soft reset from suspend with settings changed
    wr(A_PB, 8'h1e);
    wr(A_ST, ST_POS);
    apb_q.push_back(34'h0);
    host.soft_reset();
    rd(A_PB, 8'h1e);
    rd(A_SS, 8'h04);
    repeat (DLY) @(posedge pclk);
    foreach (ADR[k]) rd(ADR[k], RST[k]);
    repeat (3) @(posedge pclk);
    stop_test();
  end
endmodule // tb
